// file: include/mode_switch_pkg.sv
// constants for the mode switch checker
package mode_switch_pkg;

  // ****************************************
  // apb register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ERR_CODE = 8'h08;
  localparam logic [7:0] ADDR_ERR_AXIS_LO = 8'h0c;
  localparam logic [7:0] ADDR_ERR_AXIS_HI = 8'h10;
  localparam logic [7:0] ADDR_AXIS_MAP = 8'h14;
  localparam logic [7:0] ADDR_REAL_ONLY = 8'h18;
  localparam logic [7:0] ADDR_SYS_AXES = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h24;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h28;
  localparam logic [7:0] ADDR_HIST_BASE = 8'h40;

  // ****************************************
  // control register fields
  // ****************************************
  localparam int CTRL_NEW_FW = 0;
  localparam int CTRL_PROG_REG = 1;
  localparam int CTRL_VIRT_AXES = 2;

  // ****************************************
  // error codes
  // ****************************************
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_AXIS_BUSY = 16'h0001;
  localparam logic [15:0] ERR_RETURN_BUSY = 16'h0100;
  localparam logic [15:0] ERR_NO_PROGRAM = 16'h0200;
  localparam logic [15:0] ERR_NOT_READY = 16'h0201;
  localparam logic [15:0] ERR_SERVO_OFF = 16'h0202;

  // ****************************************
  // interrupt bits and reset values
  // ****************************************
  localparam int IRQ_ENTER_OK = 0;
  localparam int IRQ_RETURN_OK = 1;
  localparam int IRQ_REJECT = 2;
  localparam int IRQ_BITS = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] MAP_RESET = 32'h0000_0000;

  // checker states
  typedef enum logic [1:0]
  {
    ST_REAL = 2'b00,
    ST_VIRTUAL = 2'b01
  } mode_t;

endpackage : mode_switch_pkg

// file: core/error_history_mem.sv
// small memory recording the last rejected error codes
`timescale 1ns/10ps
module error_history_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 16
) (
  input wire logic mclk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata_q
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("error_history_mem: DEPTH must be a power of two");
  end

  // write port and registered read
  always_ff @(posedge mclk)
  begin
    if (we)
      mem_q[waddr] <= wdata;
    rdata_q <= mem_q[raddr];
  end

endmodule : error_history_mem

// file: core/mode_switch_checker.sv
// real/virtual mode switch request checker with apb registers
// Function
// - older builds reject an entry request with code 1 while any axis moves.
// - newer builds reject entry with code 1 only for busy program output axes.
// - newer builds ignore busy real-mode-only axes when checking a switch.
// - a return request with a busy virtual axis (any axis if older) gets 256.
// - a return request while an output module is speed-torque gets 256.
// - an entry request with no mechanical program registered gets 512.
// - an entry request with mismatched system and program axes gets 512.
// - an entry request with either ready flag low gets 513.
// - an entry request with the all-axes servo-on command low gets 514.
// - an axis is stopped when its start-accepted flag is low.
// - codes 513 and 514 leave the error axis number registers untouched.
`timescale 1ns/10ps
module mode_switch_checker #(
  parameter int AXES = 32,
  parameter int HIST_DEPTH = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic mode_switch_request,
  input wire logic [AXES-1:0] axis_start_accepted,
  input wire logic host_ready_flag,
  input wire logic motion_proc_ready_done,
  input wire logic all_axes_servo_on_cmd,
  input wire logic [AXES-1:0] speed_torque_active,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic virtual_mode,
  output logic irq
);

  localparam int HW = $clog2(HIST_DEPTH);
  localparam int IRQ_W = mode_switch_pkg::IRQ_BITS;

  initial
  begin
    if (AXES < 1 || AXES > 32)
      $error("mode_switch_checker: AXES must be 1 to 32");
  end

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [AXES+3:0] sync1_q;
  logic [AXES+3:0] sync2_q;
  logic [AXES-1:0] st_sync1_q;
  logic [AXES-1:0] st_sync2_q;
  logic req_prev_q;
  logic [AXES+3:0] sync1_d;

  // two stages for every pin input
  always_comb
  begin
    sync1_d = {mode_switch_request, host_ready_flag, motion_proc_ready_done,
               all_axes_servo_on_cmd, axis_start_accepted};
  end

  always_ff @(posedge mclk)
  begin
    sync1_q <= sync1_d;
    sync2_q <= sync1_q;
    st_sync1_q <= speed_torque_active;
    st_sync2_q <= st_sync1_q;
    if (sys_rst)
      req_prev_q <= 1'b0;
    else
      req_prev_q <= sync2_q[AXES+3];
  end

  logic req_s;
  logic host_rdy_s;
  logic proc_rdy_s;
  logic servo_s;
  logic [AXES-1:0] busy_s;
  logic rise;
  logic fall;

  // synchronised views and request edges
  always_comb
  begin
    req_s = sync2_q[AXES+3];
    host_rdy_s = sync2_q[AXES+2];
    proc_rdy_s = sync2_q[AXES+1];
    servo_s = sync2_q[AXES];
    busy_s = sync2_q[AXES-1:0];
    rise = req_s && !req_prev_q;
    fall = !req_s && req_prev_q;
  end

  // ****************************************
  // registers
  // ****************************************
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] axis_map_q;
  logic [31:0] axis_map_d;
  logic [31:0] real_only_q;
  logic [31:0] real_only_d;
  logic [31:0] sys_axes_q;
  logic [31:0] sys_axes_d;
  logic [IRQ_W-1:0] irq_en_q;
  logic [IRQ_W-1:0] irq_en_d;
  logic [IRQ_W-1:0] irq_st_q;
  logic [IRQ_W-1:0] irq_st_d;
  logic [15:0] err_code_q;
  logic [15:0] err_code_d;
  logic [15:0] err_lo_q;
  logic [15:0] err_lo_d;
  logic [15:0] err_hi_q;
  logic [15:0] err_hi_d;
  mode_switch_pkg::mode_t mode_q;
  mode_switch_pkg::mode_t mode_d;
  logic [HW-1:0] hist_wp_q;
  logic [HW-1:0] hist_wp_d;
  logic [31:0] prdata_d;
  logic pready_d;
  logic pslverr_d;
  logic irq_d;

  // ****************************************
  // decode helpers
  // ****************************************
  // true when the address names a mapped register
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a <= mode_switch_pkg::ADDR_IRQ_CLEAR && a[1:0] == 2'b00)
      || (a >= mode_switch_pkg::ADDR_HIST_BASE
          && a < mode_switch_pkg::ADDR_HIST_BASE + 8'(HIST_DEPTH * 4)
          && a[1:0] == 2'b00);
  endfunction : is_mapped

  // widen an axis mask to a register word
  function automatic logic [31:0] wide(input logic [AXES-1:0] v);
    wide = 32'(v);
  endfunction : wide

  // ****************************************
  // switch checks
  // ****************************************
  logic new_fw;
  logic [AXES-1:0] out_axes;
  logic [AXES-1:0] virt_axes;
  logic [AXES-1:0] enter_busy;
  logic [AXES-1:0] return_busy;
  logic prog_ok;
  logic [15:0] verdict;
  logic [AXES-1:0] bad_axes;

  // select the axis sets per build and grade the request edge
  always_comb
  begin
    new_fw = ctrl_q[mode_switch_pkg::CTRL_NEW_FW];
    out_axes = axis_map_q[AXES-1:0] & ~real_only_q[AXES-1:0];
    virt_axes = out_axes;
    enter_busy = new_fw ? (busy_s & out_axes) : busy_s;
    return_busy = new_fw ? (busy_s & virt_axes) : busy_s;
    prog_ok = ctrl_q[mode_switch_pkg::CTRL_PROG_REG]
      && (sys_axes_q[AXES-1:0] == axis_map_q[AXES-1:0]);
    verdict = mode_switch_pkg::ERR_NONE;
    bad_axes = '0;
    if (rise)
    begin
      if (!prog_ok)
        verdict = mode_switch_pkg::ERR_NO_PROGRAM;
      else if (!host_rdy_s || !proc_rdy_s)
        verdict = mode_switch_pkg::ERR_NOT_READY;
      else if (!servo_s)
        verdict = mode_switch_pkg::ERR_SERVO_OFF;
      else if (|enter_busy)
      begin
        verdict = mode_switch_pkg::ERR_AXIS_BUSY;
        bad_axes = enter_busy;
      end
    end
    else if (fall)
    begin
      if (|return_busy)
      begin
        verdict = mode_switch_pkg::ERR_RETURN_BUSY;
        bad_axes = return_busy;
      end
      else if (|(st_sync2_q & out_axes))
      begin
        verdict = mode_switch_pkg::ERR_RETURN_BUSY;
        bad_axes = st_sync2_q & out_axes;
      end
    end
  end

  // ****************************************
  // next state of mode, error and registers
  // ****************************************
  logic wr;
  logic rd;
  logic [IRQ_W-1:0] irq_set;
  logic [31:0] bad_word;
  logic [HW-1:0] hist_raddr;
  logic [15:0] hist_rdata;

  always_comb
  begin
    wr = psel && penable && pwrite && is_mapped(paddr);
    rd = psel && !penable && !pwrite;
    mode_d = mode_q;
    err_code_d = err_code_q;
    err_lo_d = err_lo_q;
    err_hi_d = err_hi_q;
    hist_wp_d = hist_wp_q;
    irq_set = '0;
    bad_word = wide(bad_axes);
    if (rise || fall)
    begin
      if (verdict == mode_switch_pkg::ERR_NONE)
      begin
        // mode moves only on a clean edge
        mode_d = rise ? mode_switch_pkg::ST_VIRTUAL
                      : mode_switch_pkg::ST_REAL;
        irq_set[rise ? mode_switch_pkg::IRQ_ENTER_OK
                     : mode_switch_pkg::IRQ_RETURN_OK] = 1'b1;
      end
      else
      begin
        err_code_d = verdict;
        hist_wp_d = hist_wp_q + HW'(1);
        irq_set[mode_switch_pkg::IRQ_REJECT] = 1'b1;
        if (verdict != mode_switch_pkg::ERR_NOT_READY
            && verdict != mode_switch_pkg::ERR_SERVO_OFF)
        begin
          err_lo_d = bad_word[15:0];
          err_hi_d = bad_word[31:16];
        end
      end
    end
    ctrl_d = ctrl_q;
    axis_map_d = axis_map_q;
    real_only_d = real_only_q;
    sys_axes_d = sys_axes_q;
    irq_en_d = irq_en_q;
    irq_st_d = irq_st_q;
    if (wr)
    begin
      unique case (paddr)
        mode_switch_pkg::ADDR_CTRL: ctrl_d = pwdata;
        mode_switch_pkg::ADDR_AXIS_MAP: axis_map_d = pwdata;
        mode_switch_pkg::ADDR_REAL_ONLY: real_only_d = pwdata;
        mode_switch_pkg::ADDR_SYS_AXES: sys_axes_d = pwdata;
        mode_switch_pkg::ADDR_IRQ_ENABLE: irq_en_d = pwdata[IRQ_W-1:0];
        mode_switch_pkg::ADDR_IRQ_CLEAR:
          irq_st_d = irq_st_q & ~pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    // set wins over a clear in the same cycle
    irq_st_d = irq_st_d | irq_set[IRQ_W-1:0];
    irq_d = |(irq_st_d & irq_en_d);
    hist_raddr = HW'((paddr - mode_switch_pkg::ADDR_HIST_BASE) >> 2);
    // read data of the access phase, captured at the setup cycle
    prdata_d = prdata;
    pready_d = psel && !penable;
    pslverr_d = psel && !penable && !is_mapped(paddr);
    if (rd)
    begin
      unique case (paddr)
        mode_switch_pkg::ADDR_CTRL: prdata_d = ctrl_q;
        mode_switch_pkg::ADDR_STATUS:
          prdata_d = {27'h0, servo_s, proc_rdy_s, host_rdy_s, req_s,
                      mode_q == mode_switch_pkg::ST_VIRTUAL};
        mode_switch_pkg::ADDR_ERR_CODE: prdata_d = {16'h0, err_code_q};
        mode_switch_pkg::ADDR_ERR_AXIS_LO: prdata_d = {16'h0, err_lo_q};
        mode_switch_pkg::ADDR_ERR_AXIS_HI: prdata_d = {16'h0, err_hi_q};
        mode_switch_pkg::ADDR_AXIS_MAP: prdata_d = axis_map_q;
        mode_switch_pkg::ADDR_REAL_ONLY: prdata_d = real_only_q;
        mode_switch_pkg::ADDR_SYS_AXES: prdata_d = sys_axes_q;
        mode_switch_pkg::ADDR_IRQ_STATUS: prdata_d = 32'(irq_st_q);
        mode_switch_pkg::ADDR_IRQ_ENABLE: prdata_d = 32'(irq_en_q);
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  // error history; slots are not yet readable over the bus

  error_history_mem #(
    .DEPTH(HIST_DEPTH),
    .WIDTH(16)
  ) u_hist (
    .mclk(mclk),
    .we(err_code_d != err_code_q || hist_wp_d != hist_wp_q),
    .waddr(hist_wp_q),
    .wdata(verdict),
    .raddr(hist_raddr),
    .rdata_q(hist_rdata)
  );

  // register all state
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      mode_q <= mode_switch_pkg::ST_REAL;
      err_code_q <= mode_switch_pkg::ERR_NONE;
      err_lo_q <= 16'h0000;
      err_hi_q <= 16'h0000;
      hist_wp_q <= '0;
      ctrl_q <= mode_switch_pkg::CTRL_RESET;
      axis_map_q <= mode_switch_pkg::MAP_RESET;
      real_only_q <= mode_switch_pkg::MAP_RESET;
      sys_axes_q <= mode_switch_pkg::MAP_RESET;
      irq_en_q <= '0;
      irq_st_q <= '0;
      irq <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      virtual_mode <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      err_code_q <= err_code_d;
      err_lo_q <= err_lo_d;
      err_hi_q <= err_hi_d;
      hist_wp_q <= hist_wp_d;
      ctrl_q <= ctrl_d;
      axis_map_q <= axis_map_d;
      real_only_q <= real_only_d;
      sys_axes_q <= sys_axes_d;
      irq_en_q <= irq_en_d;
      irq_st_q <= irq_st_d;
      irq <= irq_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
      virtual_mode <= (mode_d == mode_switch_pkg::ST_VIRTUAL);
    end
  end

endmodule : mode_switch_checker

// file: tb/mode_switch_checker_properties.sv
// port-level checks on the mode switch checker
`timescale 1ns/10ps
module mode_switch_checker_properties #(
  parameter int AXES = 32,
  parameter int HIST_DEPTH = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic mode_switch_request,
  input wire logic [AXES-1:0] axis_start_accepted,
  input wire logic host_ready_flag,
  input wire logic motion_proc_ready_done,
  input wire logic all_axes_servo_on_cmd,
  input wire logic [AXES-1:0] speed_torque_active,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic virtual_mode,
  input wire logic irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // mode entry needs both ready flags and servo-on
  a_enter_ready: assert property ($rose(virtual_mode) |->
    $past(host_ready_flag) && $past(motion_proc_ready_done))
    else $error("mode entered while not ready");
  a_enter_servo: assert property ($rose(virtual_mode) |->
    $past(all_axes_servo_on_cmd)) else $error("mode entered with servo off");
  a_enter_request: assert property ($rose(virtual_mode) |->
    mode_switch_request && $past(mode_switch_request, 3))
    else $error("mode entered without request");
  // return only on a low request, never out of position control
  a_return_request: assert property ($fell(virtual_mode) &&
    !$past(sys_rst) |-> !$past(mode_switch_request, 3))
    else $error("mode returned without request low");
  a_return_speed: assert property ($fell(virtual_mode) &&
    !$past(sys_rst) |-> $past(speed_torque_active) == '0)
    else $error("mode returned during speed-torque control");
  a_mode_quiet: assert property ($stable(mode_switch_request)[*6] |->
    $stable(virtual_mode)) else $error("mode changed with no request edge");
  // bus answers: zero wait states, one cycle
  a_pready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_pready_only: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");

  c_enter: cover property ($rose(virtual_mode));
  c_return: cover property ($fell(virtual_mode));
  c_slverr: cover property (pslverr);
endmodule : mode_switch_checker_properties

bind mode_switch_checker mode_switch_checker_properties #(.AXES(AXES),
  .HIST_DEPTH(HIST_DEPTH)) u_props (.mclk(mclk), .sys_rst(sys_rst),
  .mode_switch_request(mode_switch_request),
  .axis_start_accepted(axis_start_accepted),
  .host_ready_flag(host_ready_flag),
  .motion_proc_ready_done(motion_proc_ready_done),
  .all_axes_servo_on_cmd(all_axes_servo_on_cmd),
  .speed_torque_active(speed_torque_active), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .virtual_mode(virtual_mode), .irq(irq));

// file: tb/host_seq_model.sv
// host sequence program model driving the switch pins
`timescale 1ns/10ps
module host_seq_model #(
  parameter int AXES = 32
) (
  input wire logic mclk,
  output logic req,
  output logic host_rdy,
  output logic proc_rdy,
  output logic servo,
  output logic [AXES-1:0] busy,
  output logic [AXES-1:0] spd_trq
);
  // quiet start: flags low, axes stopped
  initial
  begin
    req = 1'b0;
    host_rdy = 1'b0;
    proc_rdy = 1'b0;
    servo = 1'b0;
    busy = '0;
    spd_trq = '0;
  end

  // flags settle well before any request edge
  task automatic flags(input logic h, input logic p, input logic s);
    host_rdy <= h;
    proc_rdy <= p;
    servo <= s;
    repeat (4) @(posedge mclk);
  endtask : flags

  // per-axis start-accepted, high while moving
  task automatic axes(input logic [AXES-1:0] b, input logic [AXES-1:0] t);
    busy <= b;
    spd_trq <= t;
    repeat (4) @(posedge mclk);
  endtask : axes

  // request edge, then time for sync and update
  task automatic toggle(input logic v);
    req <= v;
    repeat (8) @(posedge mclk);
  endtask : toggle
endmodule : host_seq_model

// file: tb/tb.sv
// self-checking bench for the mode switch checker
`timescale 1ns/10ps
module tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic virtual_mode;
  logic irq;
  logic req;
  logic hr;
  logic pr;
  logic sv;
  logic [31:0] busy;
  logic [31:0] st;
  logic [31:0] r;
  logic e;
  int fail_count = 0;
  int n_compared = 0;

  // 40 MHz clock
  always #12.5 mclk = ~mclk;

  host_seq_model u_host (.mclk(mclk), .req(req), .host_rdy(hr),
    .proc_rdy(pr), .servo(sv), .busy(busy), .spd_trq(st));

  mode_switch_checker u_dut (.mclk(mclk), .sys_rst(sys_rst),
    .mode_switch_request(req), .axis_start_accepted(busy),
    .host_ready_flag(hr), .motion_proc_ready_done(pr),
    .all_axes_servo_on_cmd(sv), .speed_torque_active(st), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .virtual_mode(virtual_mode), .irq(irq));

  // verdict and end of run
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  // word and bit comparisons
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask : chk1

  // one apb transfer, bounded wait for pready
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    logic ok;
    ok = 1'b0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (int n = 0; n < 20 && !ok; n++)
    begin
      @(posedge mclk);
      ok = (pready === 1'b1);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (!ok)
    begin
      fail_count++;
      summarize();
    end
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk32(r, exp);
  endtask : rd

  // entry attempt expected to be refused, then always drop the request
  task automatic entry(input logic [15:0] code, input logic [31:0] lo);
    u_host.toggle(1'b1);
    chk1(virtual_mode, 1'b0);
    rd(mode_switch_pkg::ADDR_ERR_CODE, {16'h0000, code});
    rd(mode_switch_pkg::ADDR_ERR_AXIS_LO, lo);
    u_host.toggle(1'b0);
  endtask : entry

  // main sequence
  initial
  begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(mode_switch_pkg::ADDR_CTRL, mode_switch_pkg::CTRL_RESET);
    apb(1'b1, mode_switch_pkg::ADDR_IRQ_ENABLE, 32'h0000_0007);
    apb(1'b1, mode_switch_pkg::ADDR_AXIS_MAP, 32'h0000_0003);
    apb(1'b1, mode_switch_pkg::ADDR_SYS_AXES, 32'h0000_0003);
    apb(1'b1, mode_switch_pkg::ADDR_REAL_ONLY, 32'h0000_0004);
    u_host.flags(1'b1, 1'b1, 1'b1);
    entry(mode_switch_pkg::ERR_NO_PROGRAM, 32'h0);
    apb(1'b1, mode_switch_pkg::ADDR_CTRL, 32'h0000_0003);
    apb(1'b1, mode_switch_pkg::ADDR_SYS_AXES, 32'h0000_0001);
    entry(mode_switch_pkg::ERR_NO_PROGRAM, 32'h0);
    apb(1'b1, mode_switch_pkg::ADDR_SYS_AXES, 32'h0000_0003);
    u_host.axes(32'h1, 32'h0);
    entry(mode_switch_pkg::ERR_AXIS_BUSY, 32'h1);
    u_host.axes(32'h0, 32'h0);
    u_host.flags(1'b0, 1'b1, 1'b1);
    entry(mode_switch_pkg::ERR_NOT_READY, 32'h1);
    u_host.flags(1'b1, 1'b0, 1'b1);
    entry(mode_switch_pkg::ERR_NOT_READY, 32'h1);
    u_host.flags(1'b1, 1'b1, 1'b0);
    entry(mode_switch_pkg::ERR_SERVO_OFF, 32'h1);
    u_host.flags(1'b1, 1'b1, 1'b1);
    apb(1'b1, mode_switch_pkg::ADDR_CTRL, 32'h0000_0002);
    u_host.axes(32'h4, 32'h0);
    entry(mode_switch_pkg::ERR_AXIS_BUSY, 32'h4);
    apb(1'b1, mode_switch_pkg::ADDR_CTRL, 32'h0000_0003);
    apb(1'b1, mode_switch_pkg::ADDR_IRQ_CLEAR, 32'h0000_0007);
    u_host.toggle(1'b1);
    chk1(virtual_mode, 1'b1);
    rd(mode_switch_pkg::ADDR_IRQ_STATUS, 32'h1);
    chk1(irq, 1'b1);
    apb(1'b1, mode_switch_pkg::ADDR_IRQ_CLEAR, 32'h0000_0001);
    rd(mode_switch_pkg::ADDR_IRQ_STATUS, 32'h0);
    chk1(irq, 1'b0);
    apb(1'b1, mode_switch_pkg::ADDR_IRQ_ENABLE, 32'h0000_0003);
    u_host.axes(32'h1, 32'h0);
    u_host.toggle(1'b0);
    chk1(virtual_mode, 1'b1);
    rd(mode_switch_pkg::ADDR_ERR_CODE, 32'h0100);
    rd(mode_switch_pkg::ADDR_IRQ_STATUS, 32'h4);
    chk1(irq, 1'b0);
    apb(1'b1, mode_switch_pkg::ADDR_IRQ_ENABLE, 32'h0000_0007);
    rd(mode_switch_pkg::ADDR_STATUS, 32'h0000_001d);
    chk1(irq, 1'b1);
    u_host.axes(32'h0, 32'h0);
    u_host.toggle(1'b1);
    u_host.axes(32'h0, 32'h6);
    u_host.toggle(1'b0);
    chk1(virtual_mode, 1'b1);
    rd(mode_switch_pkg::ADDR_ERR_AXIS_LO, 32'h2);
    u_host.axes(32'h0, 32'h0);
    u_host.toggle(1'b1);
    u_host.toggle(1'b0);
    chk1(virtual_mode, 1'b0);
    apb(1'b0, 8'h30, 32'h0000_0000);
    chk1(e, 1'b1);
    chk32(r, 32'h0);
    summarize();
  end
endmodule : tb
